// File: tws_defs.svh
`ifndef TWS_DEFS_SVH
`define TWS_DEFS_SVH

// Device-type identifier; value is arbitrary
`define TWS_DEV_ID 4'h5
`define TWS_ADDR_W 11
`define TWS_PAGE_W 4
`define TWS_MEM_WORDS 2048
`define TWS_PAGE_BYTES 16

`define TWS_CLK_SYS_KHZ 40000
`define TWS_SCL_KHZ 100
`define TWS_QTR_CYCLES (`TWS_CLK_SYS_KHZ / (4 * `TWS_SCL_KHZ))

`define TWS_LINK_CLK_NS 6
`define TWS_WR_PERIOD_US 5000
`define TWS_WR_CYCLES ((`TWS_WR_PERIOD_US * 1000) / `TWS_LINK_CLK_NS)
`define TWS_FILTER_NS 100
`define TWS_FILTER_CYCLES (`TWS_FILTER_NS / `TWS_LINK_CLK_NS)

`endif

// File: tws_pkg.sv
package tws_pkg;

  typedef enum logic [6:0] {
    S_IDLE     = 7'b0000001,
    S_DEVADDR  = 7'b0000010,
    S_WORDADDR = 7'b0000100,
    S_WDATA    = 7'b0001000,
    S_RDATA    = 7'b0010000,
    S_WAITSTOP = 7'b0100000,
    S_BUSY     = 7'b1000000
  } tws_dev_state_t;

  typedef enum logic [1:0] {
    H_IDLE = 2'b01,
    H_RUN  = 2'b10
  } tws_host_state_t;

  typedef enum logic [3:0] {
    K_START = 4'b0001,
    K_WR    = 4'b0010,
    K_RD    = 4'b0100,
    K_STOP  = 4'b1000
  } tws_step_t;

endpackage

// File: tws_if.sv
`timescale 1ns/1ps
`default_nettype none

interface tws_if;
  logic sclOut;
  logic sclOeN;
  logic hSdaOut;
  logic hSdaOeN;
  logic dSdaOut;
  logic dSdaOeN;
  logic scl;
  logic sda;

  // Open-drain wires with pull-ups: any enabled low driver wins
  assign scl = !(!sclOeN && !sclOut);
  assign sda = !((!hSdaOeN && !hSdaOut) || (!dSdaOeN && !dSdaOut));

  modport host (output sclOut, output sclOeN, output hSdaOut, output hSdaOeN, input sda);
  modport dev (output dSdaOut, output dSdaOeN, input scl, input sda);
endinterface

`default_nettype wire

// File: tws_eeprom_dev.sv
`timescale 1ns/1ps
`default_nettype none
`include "tws_defs.svh"

module tws_eeprom_dev #(
  parameter int unsigned WR_CYCLES = `TWS_WR_CYCLES
) (
  input  wire logic linkClk,
  input  wire logic rst,
  tws_if.dev        bus,
  output logic      busy,
  output logic      writeDone
);
  import tws_pkg::*;

  logic [1:0]            syncA_r;
  logic [1:0]            syncB_r;
  logic [1:0]            filt;
  logic                  sclPrev_r;
  logic                  sdaPrev_r;
  logic                  scl;
  logic                  sda;
  logic                  sclRise;
  logic                  sclFall;
  logic                  startSeen;
  logic                  stopSeen;
  tws_dev_state_t        state_r;
  logic [3:0]            bitCnt_r;
  logic                  ackPhase_r;
  logic                  sdaOeN_r;
  logic [7:0]            shift_r;
  logic [`TWS_ADDR_W-1:0] addr_r;
  logic [2:0]            hiBits_r;
  logic [6:0]            pageHi_r;
  logic [19:0]           busyCnt_r;
  logic                  byteDone;
  logic                  commit;
  logic [7:0]            mem [`TWS_MEM_WORDS];
  logic [7:0]            pageBuf_r [`TWS_PAGE_BYTES];
  logic [15:0]           mask_r;
  logic [7:0]            memRd;

  // Index 0 is the clock line, index 1 the data line
  always_ff @(posedge linkClk or posedge rst) begin
    if (rst) begin
      syncA_r <= 2'h3;
      syncB_r <= 2'h3;
    end else begin
      syncA_r <= {bus.sda, bus.scl};
      syncB_r <= syncA_r;
    end
  end

  // Spike filter: a level must hold for the filter time before it counts
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gFilt
      logic [4:0] cnt_r;
      logic       f_r;
      always_ff @(posedge linkClk or posedge rst) begin
        if (rst) begin
          cnt_r <= 5'h00;
          f_r   <= 1'b1;
        end else if (syncB_r[g] == f_r) begin
          cnt_r <= 5'h00;
        end else if (cnt_r == 5'(`TWS_FILTER_CYCLES - 1)) begin
          f_r   <= syncB_r[g];
          cnt_r <= 5'h00;
        end else begin
          cnt_r <= cnt_r + 5'h01;
        end
      end
      assign filt[g] = f_r;
    end
  endgenerate

  assign scl = filt[0];
  assign sda = filt[1];

  always_ff @(posedge linkClk or posedge rst) begin
    if (rst) begin
      sclPrev_r <= 1'b1;
      sdaPrev_r <= 1'b1;
    end else begin
      sclPrev_r <= scl;
      sdaPrev_r <= sda;
    end
  end

  assign sclRise   = scl && !sclPrev_r;
  assign sclFall   = !scl && sclPrev_r;
  assign startSeen = scl && sclPrev_r && sdaPrev_r && !sda;
  assign stopSeen  = scl && sclPrev_r && !sdaPrev_r && sda;
  assign byteDone  = sclFall && !ackPhase_r && (bitCnt_r == 4'h8);
  assign commit    = (state_r == S_BUSY) && (busyCnt_r == 20'h00001);
  assign memRd     = mem[addr_r];

  always_ff @(posedge linkClk or posedge rst) begin
    if (rst) begin
      state_r    <= S_IDLE;
      bitCnt_r   <= 4'h0;
      ackPhase_r <= 1'b0;
      sdaOeN_r   <= 1'b1;
      shift_r    <= 8'h00;
      addr_r     <= 11'h000;
      hiBits_r   <= 3'h0;
      pageHi_r   <= 7'h00;
      busyCnt_r  <= 20'h00000;
    end else if (state_r == S_BUSY) begin
      // Inputs are dead until the write period ends; no ack is possible
      busyCnt_r <= busyCnt_r - 20'h00001;
      if (commit) begin
        state_r <= S_IDLE;
      end
    end else if (stopSeen) begin
      sdaOeN_r   <= 1'b1;
      ackPhase_r <= 1'b0;
      if (state_r == S_WDATA && mask_r != 16'h0000) begin
        state_r   <= S_BUSY;
        busyCnt_r <= 20'(WR_CYCLES);
      end else begin
        state_r <= S_IDLE;
      end
    end else if (startSeen) begin
      state_r    <= S_DEVADDR;
      bitCnt_r   <= 4'h0;
      ackPhase_r <= 1'b0;
      sdaOeN_r   <= 1'b1;
    end else begin
      case (state_r)
        S_DEVADDR, S_WORDADDR, S_WDATA: begin
          if (sclRise && !ackPhase_r && bitCnt_r < 4'h8) begin
            shift_r  <= {shift_r[6:0], sda};
            bitCnt_r <= bitCnt_r + 4'h1;
          end else if (sclFall && ackPhase_r) begin
            ackPhase_r <= 1'b0;
            sdaOeN_r   <= 1'b1;
            bitCnt_r   <= 4'h0;
          end else if (byteDone) begin
            case (state_r)
              S_DEVADDR: begin
                if (shift_r[7:4] == `TWS_DEV_ID) begin
                  sdaOeN_r <= 1'b0;
                  hiBits_r <= shift_r[3:1];
                  if (shift_r[0]) begin
                    state_r  <= S_RDATA;
                    bitCnt_r <= 4'h9;
                  end else begin
                    state_r    <= S_WORDADDR;
                    ackPhase_r <= 1'b1;
                  end
                end else begin
                  state_r <= S_IDLE;
                end
              end
              S_WORDADDR: begin
                sdaOeN_r   <= 1'b0;
                ackPhase_r <= 1'b1;
                addr_r     <= {hiBits_r, shift_r};
                pageHi_r   <= {hiBits_r, shift_r[7:4]};
                state_r    <= S_WDATA;
              end
              default: begin
                sdaOeN_r   <= 1'b0;
                ackPhase_r <= 1'b1;
                // Only the in-page bits move, so extra bytes wrap the page
                addr_r[3:0] <= addr_r[3:0] + 4'h1;
              end
            endcase
          end
        end
        S_RDATA: begin
          if (sclRise && bitCnt_r == 4'h9 && sda) begin
            state_r <= S_WAITSTOP;
          end else if (sclFall && bitCnt_r == 4'h9) begin
            sdaOeN_r <= memRd[7];
            shift_r  <= {memRd[6:0], 1'b0};
            bitCnt_r <= 4'h1;
            addr_r   <= addr_r + 11'h001;
          end else if (sclFall && bitCnt_r == 4'h8) begin
            sdaOeN_r <= 1'b1;
            bitCnt_r <= 4'h9;
          end else if (sclFall) begin
            sdaOeN_r <= shift_r[7];
            shift_r  <= {shift_r[6:0], 1'b0};
            bitCnt_r <= bitCnt_r + 4'h1;
          end
        end
        default: begin
          sdaOeN_r <= 1'b1;
        end
      endcase
    end
  end

  // Page buffer collects bytes; nothing reaches the array before STOP
  always_ff @(posedge linkClk or posedge rst) begin
    if (rst) begin
      mask_r <= 16'h0000;
    end else if (byteDone && state_r == S_WORDADDR && !startSeen && !stopSeen) begin
      mask_r <= 16'h0000;
    end else if (byteDone && state_r == S_WDATA && !startSeen && !stopSeen) begin
      mask_r[addr_r[3:0]] <= 1'b1;
    end else if (commit) begin
      mask_r <= 16'h0000;
    end
  end

  always_ff @(posedge linkClk) begin
    if (byteDone && state_r == S_WDATA && !startSeen && !stopSeen) begin
      pageBuf_r[addr_r[3:0]] <= shift_r;
    end
  end

  // Array is nonvolatile, so it is left out of reset
  always_ff @(posedge linkClk) begin
    for (int i = 0; i < `TWS_PAGE_BYTES; i++) begin
      if (commit && mask_r[i]) begin
        mem[{pageHi_r, 4'(i)}] <= pageBuf_r[i];
      end
    end
  end

  always_ff @(posedge linkClk or posedge rst) begin
    if (rst) begin
      busy      <= 1'b0;
      writeDone <= 1'b0;
    end else begin
      busy      <= (state_r == S_BUSY);
      writeDone <= commit;
    end
  end

  assign bus.dSdaOut = 1'b0;
  assign bus.dSdaOeN = sdaOeN_r;
endmodule

`default_nettype wire

// File: tws_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "tws_defs.svh"

module tws_host (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  tws_if.host              bus,
  input  wire logic        reqValid,
  input  wire logic        reqRead,
  input  wire logic [10:0] reqAddr,
  input  wire logic [7:0]  reqWdata,
  output logic             reqReady,
  output logic             doneValid,
  output logic             doneNack,
  output logic [7:0]       rdData
);
  import tws_pkg::*;

  tws_host_state_t st_r;
  tws_step_t       kind;
  logic [7:0]      stepByte;
  logic [2:0]      stepIdx_r;
  logic [1:0]      q_r;
  logic [6:0]      tickCnt_r;
  logic            tick;
  logic [3:0]      bitCnt_r;
  logic [7:0]      rdShift_r;
  logic            nack_r;
  logic            read_r;
  logic [10:0]     addr_r;
  logic [7:0]      wdata_r;
  logic            sclOeN_r;
  logic            sdaOeN_r;
  logic            sdaA_r;
  logic            sdaS_r;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sdaA_r <= 1'b1;
      sdaS_r <= 1'b1;
    end else begin
      sdaA_r <= bus.sda;
      sdaS_r <= sdaA_r;
    end
  end

  // Write: START ctl addr data STOP; read: START ctl addr START ctl data STOP
  always_comb begin
    kind     = K_STOP;
    stepByte = 8'h00;
    case (stepIdx_r)
      3'h0: kind = K_START;
      3'h1: begin
        kind     = K_WR;
        stepByte = {`TWS_DEV_ID, addr_r[10:8], 1'b0};
      end
      3'h2: begin
        kind     = K_WR;
        stepByte = addr_r[7:0];
      end
      3'h3: begin
        kind     = read_r ? K_START : K_WR;
        stepByte = wdata_r;
      end
      3'h4: begin
        kind     = read_r ? K_WR : K_STOP;
        stepByte = {`TWS_DEV_ID, addr_r[10:8], 1'b1};
      end
      3'h5: kind = read_r ? K_RD : K_STOP;
      default: kind = K_STOP;
    endcase
  end

  assign tick = (tickCnt_r == 7'(`TWS_QTR_CYCLES - 1));

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tickCnt_r <= 7'h00;
    end else if (st_r == H_IDLE || tick) begin
      tickCnt_r <= 7'h00;
    end else begin
      tickCnt_r <= tickCnt_r + 7'h01;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_r      <= H_IDLE;
      stepIdx_r <= 3'h0;
      q_r       <= 2'h0;
      bitCnt_r  <= 4'h0;
      rdShift_r <= 8'h00;
      nack_r    <= 1'b0;
      read_r    <= 1'b0;
      addr_r    <= 11'h000;
      wdata_r   <= 8'h00;
      sclOeN_r  <= 1'b1;
      sdaOeN_r  <= 1'b1;
      reqReady  <= 1'b1;
      doneValid <= 1'b0;
      doneNack  <= 1'b0;
      rdData    <= 8'h00;
    end else begin
      doneValid <= 1'b0;
      case (st_r)
        H_IDLE: begin
          if (reqValid && reqReady) begin
            st_r      <= H_RUN;
            read_r    <= reqRead;
            addr_r    <= reqAddr;
            wdata_r   <= reqWdata;
            stepIdx_r <= 3'h0;
            q_r       <= 2'h0;
            bitCnt_r  <= 4'h0;
            nack_r    <= 1'b0;
            reqReady  <= 1'b0;
          end
        end
        H_RUN: begin
          if (tick) begin
            q_r <= q_r + 2'h1;
            // Bits move in quarter 0 with the clock low; START and STOP move data in quarter 2, clock high
            case (kind)
              K_START: begin
                case (q_r)
                  2'h0: sdaOeN_r <= 1'b1;
                  2'h1: sclOeN_r <= 1'b1;
                  2'h2: sdaOeN_r <= 1'b0;
                  default: begin
                    sclOeN_r  <= 1'b0;
                    stepIdx_r <= stepIdx_r + 3'h1;
                  end
                endcase
              end
              K_WR: begin
                case (q_r)
                  2'h0: sdaOeN_r <= (bitCnt_r == 4'h8) ? 1'b1 : stepByte[3'h7 - bitCnt_r[2:0]];
                  2'h1: sclOeN_r <= 1'b1;
                  2'h2: if (bitCnt_r == 4'h8 && sdaS_r) nack_r <= 1'b1;
                  default: begin
                    sclOeN_r <= 1'b0;
                    if (bitCnt_r == 4'h8) begin
                      bitCnt_r  <= 4'h0;
                      stepIdx_r <= nack_r ? 3'h7 : stepIdx_r + 3'h1;
                    end else begin
                      bitCnt_r <= bitCnt_r + 4'h1;
                    end
                  end
                endcase
              end
              K_RD: begin
                // Released on the ninth bit too: a single byte ends with no ack
                case (q_r)
                  2'h0: sdaOeN_r <= 1'b1;
                  2'h1: sclOeN_r <= 1'b1;
                  2'h2: if (bitCnt_r < 4'h8) rdShift_r <= {rdShift_r[6:0], sdaS_r};
                  default: begin
                    sclOeN_r <= 1'b0;
                    if (bitCnt_r == 4'h8) begin
                      bitCnt_r  <= 4'h0;
                      rdData    <= rdShift_r;
                      stepIdx_r <= stepIdx_r + 3'h1;
                    end else begin
                      bitCnt_r <= bitCnt_r + 4'h1;
                    end
                  end
                endcase
              end
              default: begin
                case (q_r)
                  2'h0: sdaOeN_r <= 1'b0;
                  2'h1: sclOeN_r <= 1'b1;
                  2'h2: sdaOeN_r <= 1'b1;
                  default: begin
                    st_r      <= H_IDLE;
                    doneValid <= 1'b1;
                    doneNack  <= nack_r;
                    reqReady  <= 1'b1;
                  end
                endcase
              end
            endcase
          end
        end
        default: st_r <= H_IDLE;
      endcase
    end
  end

  assign bus.sclOut  = 1'b0;
  assign bus.sclOeN  = sclOeN_r;
  assign bus.hSdaOut = 1'b0;
  assign bus.hSdaOeN = sdaOeN_r;
endmodule

`default_nettype wire

// File: tws_link_properties.sv
`timescale 1ns/1ps
`default_nettype none

module tws_link_properties #(
  parameter int unsigned WR_CYCLES = 200
) (
  input wire logic clk_sys,
  input wire logic linkClk,
  input wire logic rst,
  input wire logic sclOeN,
  input wire logic hSdaOeN,
  input wire logic dSdaOeN,
  input wire logic scl,
  input wire logic sda,
  input wire logic busy,
  input wire logic writeDone,
  input wire logic reqReady,
  input wire logic doneValid
);
  int unsigned busyCnt_r;

  // Counts the busy stretch so its length can be judged when it ends
  always_ff @(posedge linkClk or posedge rst) begin
    if (rst) begin
      busyCnt_r <= 0;
    end else if (busy) begin
      busyCnt_r <= busyCnt_r + 1;
    end else begin
      busyCnt_r <= 0;
    end
  end

  a_host_idle_free: assert property (@(posedge clk_sys) disable iff (rst)
    reqReady |-> sclOeN && hSdaOeN) else $error("host holds a line while idle");
  a_start_opens_frame: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(reqReady) |-> (sclOeN throughout (##[150:300] !hSdaOeN)))
    else $error("frame does not open with data falling under high clock");
  a_stop_frees_bus: assert property (@(posedge clk_sys) disable iff (rst)
    doneValid |-> scl && sda) else $error("bus not free when transfer ends");
  a_done_one_cycle: assert property (@(posedge clk_sys) disable iff (rst)
    doneValid |=> !doneValid) else $error("done pulse longer than one cycle");
  a_ready_after_done: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(reqReady) |-> doneValid) else $error("ready returned without done");
  a_dev_edge_low: assert property (@(posedge linkClk) disable iff (rst)
    $changed(dSdaOeN) |-> !scl) else $error("device moved data while clock high");
  a_busy_silent: assert property (@(posedge linkClk) disable iff (rst)
    busy |-> dSdaOeN) else $error("device drives data while busy");
  a_commit_ends_busy: assert property (@(posedge linkClk) disable iff (rst)
    writeDone |=> !busy && !writeDone) else $error("busy outlasts commit pulse");
  a_busy_length: assert property (@(posedge linkClk) disable iff (rst)
    $fell(busy) |-> busyCnt_r >= WR_CYCLES - 1 && busyCnt_r <= WR_CYCLES + 3)
    else $error("write period length wrong");
endmodule

`default_nettype wire

// File: tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
  import tws_pkg::*;

  // Long enough that a poll frame reaches its ack bit inside the period
  localparam int unsigned WR_CYC = 20000;
  localparam int LIMIT = 25000;

  logic        clk_sys;
  logic        linkClk;
  logic        rst;
  logic        reqValid;
  logic        reqRead;
  logic [10:0] reqAddr;
  logic [7:0]  reqWdata;
  logic        reqReady;
  logic        doneValid;
  logic        doneNack;
  logic [7:0]  rdData;
  logic        busy;
  logic        writeDone;
  logic        seenNack;
  logic [7:0]  seenData;
  logic [7:0]  wireByte;
  logic        wireAck;
  int          bitIdx;
  int          fail_count;
  int          cmp_count;

  tws_if twsBus();

  tws_host tws_host_inst (.clk_sys(clk_sys), .rst(rst), .bus(twsBus), .reqValid(reqValid),
    .reqRead(reqRead), .reqAddr(reqAddr), .reqWdata(reqWdata), .reqReady(reqReady),
    .doneValid(doneValid), .doneNack(doneNack), .rdData(rdData));

  tws_eeprom_dev #(.WR_CYCLES(WR_CYC)) tws_eeprom_dev_inst (.linkClk(linkClk), .rst(rst),
    .bus(twsBus), .busy(busy), .writeDone(writeDone));

  tws_link_properties #(.WR_CYCLES(WR_CYC)) tws_link_properties_inst (.clk_sys(clk_sys),
    .linkClk(linkClk), .rst(rst), .sclOeN(twsBus.sclOeN), .hSdaOeN(twsBus.hSdaOeN),
    .dSdaOeN(twsBus.dSdaOeN), .scl(twsBus.scl), .sda(twsBus.sda), .busy(busy),
    .writeDone(writeDone), .reqReady(reqReady), .doneValid(doneValid));

  always #12.5 clk_sys = ~clk_sys;

  // Link clock period has no common phase with the system clock
  always #3 linkClk = ~linkClk;

  // Wire monitor: first byte and its ninth bit after the latest start
  always @(negedge twsBus.sda) begin
    if (twsBus.scl === 1'b1) begin
      bitIdx = 0;
    end
  end

  always @(posedge twsBus.scl) begin
    if (bitIdx < 8) begin
      wireByte = {wireByte[6:0], twsBus.sda};
    end else if (bitIdx == 8) begin
      wireAck = twsBus.sda;
    end
    bitIdx = bitIdx + 1;
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic give_up(input string what);
    fail_count++;
    $display("Error %s timed out", what);
    final_report();
  endtask

  task automatic access(input logic rd, input logic [10:0] addr, input logic [7:0] data);
    int n;
    @(posedge clk_sys);
    reqValid <= 1'b1;
    reqRead <= rd;
    reqAddr <= addr;
    reqWdata <= data;
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (reqReady !== 1'b0 && n < LIMIT);
    if (n >= LIMIT) give_up("request take");
    @(posedge clk_sys);
    reqValid <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (doneValid !== 1'b1 && n < LIMIT);
    if (n >= LIMIT) give_up("request done");
    seenNack = doneNack;
    seenData = rdData;
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (busy !== 1'b0 && n < LIMIT);
    if (n >= LIMIT) give_up("write period");
  endtask

  initial begin
    clk_sys = 1'b0;
    linkClk = 1'b0;
    rst = 1'b1;
    reqValid = 1'b0;
    reqRead = 1'b0;
    reqAddr = 11'h000;
    reqWdata = 8'h00;
    fail_count = 0;
    cmp_count = 0;
    bitIdx = 9;
    wireByte = 8'h00;
    wireAck = 1'b1;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    check("scl idle", {7'h00, twsBus.scl}, 8'h01);
    check("sda idle", {7'h00, twsBus.sda}, 8'h01);
    check("busy idle", {7'h00, busy}, 8'h00);
    $display("test reset done");
    access(1'b0, 11'h123, 8'ha5);
    check("write nack", {7'h00, seenNack}, 8'h00);
    check("write control byte", wireByte, 8'h52);
    check("write control ack", {7'h00, wireAck}, 8'h00);
    check("busy after stop", {7'h00, busy}, 8'h01);
    $display("test byte write done");
    access(1'b1, 11'h123, 8'h00);
    check("poll nack", {7'h00, seenNack}, 8'h01);
    check("poll control ack", {7'h00, wireAck}, 8'h01);
    $display("test ack polling done");
    wait_idle();
    access(1'b0, 11'h523, 8'h3c);
    check("second control byte", wireByte, 8'h5a);
    check("second write nack", {7'h00, seenNack}, 8'h00);
    $display("test second write done");
    wait_idle();
    access(1'b1, 11'h123, 8'h00);
    check("read nack", {7'h00, seenNack}, 8'h00);
    check("read control id", {4'h0, wireByte[7:4]}, 8'h05);
    check("read control rw", {7'h00, wireByte[0]}, 8'h01);
    check("read first page", seenData, 8'ha5);
    access(1'b1, 11'h523, 8'h00);
    check("read second page", seenData, 8'h3c);
    $display("test read back done");
    final_report();
  end
endmodule

`default_nettype wire
